// ### hw/fbec_telegram_rx.sv
/*
 * Collects the eight telegram bytes written by software into a frame and
 * pulses frameDone when the last byte arrives.
 * Assumes bytes come one per strobe, first byte marked by frameStart.
 */
module fbec_telegram_rx (
    // clock and reset
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          ce,
    // byte stream
    input  wire logic          byteValid,
    input  wire logic [7:0]    byteData,
    input  wire logic          frameStart,
    // assembled frame
    fbec_frame_if.assembler    frame
);
    import fbec_pkg::*;

    logic [7:0] bytes      [TELEGRAM_LEN];
    logic [7:0] next_bytes [TELEGRAM_LEN];
    logic [2:0] byteIndex;
    logic [2:0] next_byteIndex;
    logic       done;
    logic       next_done;

    always_comb begin
        logic [2:0] slot;
        slot           = frameStart ? 3'h0 : byteIndex;
        next_bytes     = bytes;
        next_byteIndex = byteIndex;
        next_done      = 1'b0;
        if (byteValid) begin
            next_bytes[slot] = byteData;
            next_byteIndex   = slot + 3'h1;
            next_done        = (slot == 3'(TELEGRAM_LEN - 1));
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < TELEGRAM_LEN; i++) begin
                bytes[i] <= 8'h00;
            end
            byteIndex <= 3'h0;
            done      <= 1'b0;
        end else if (ce) begin
            bytes     <= next_bytes;
            byteIndex <= next_byteIndex;
            done      <= next_done;
        end
    end

    assign frame.frameDone             = done;
    assign frame.telegramTag           = bytes[0];
    assign frame.slaveCount            = bytes[1];
    assign frame.command               = bytes[2];
    assign frame.specialFunctionByte   = bytes[3];
    assign frame.branch1SetValue       = {bytes[4], bytes[5]};
    assign frame.branch1SecondSetValue = {bytes[6], bytes[7]};

endmodule : fbec_telegram_rx

// ### hw/fbec_top.sv
/*
 * Control core for the process-data write telegram: control byte decode,
 * output gating by enable pin and bus disable, error latch, per-branch
 * remote loop switchover, comparator test output and register port.
 * Assumes pin inputs are asynchronous and errorDetect is on core_clk.
 */
// Local design decisions: the strobed register port and the placing of the registers.
// Notes on behaviour
// - no output drive without enable pin high
// - bus disable blocks outputs, drive drops zero
// - bus disable set then released acknowledges errors
// - enable pin falling clears pending bus disable
// - status shows bus disable and pin enable
// - branch 1 comparator inputs zero until request
// - branch 1 closes on select, request, comparator low
// - per-branch closed loop active status
// - branch 2 same switchover and zero hold
// - aux comparator bits read comparator state
// - test bit forces comparator output when permitted
// - decode test and bus disable, drop bits 0 and 4, store the rest
// - control byte only with enable, else zero
// - status high byte bit positions fixed
// - error discards set points, disables outputs
module fbec_top (
    // clock and reset
    input  wire logic                    core_clk,
    input  wire logic                    rst_n,
    input  wire logic                    ce,
    // register port
    input  wire logic [fbec_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [fbec_pkg::DATA_W-1:0] regWrData,
    input  wire logic                    regWrite,
    input  wire logic                    regRead,
    output logic      [fbec_pkg::DATA_W-1:0] regRdData,
    // pins
    input  wire logic                    pinEnable,
    input  wire logic                    loopRequestB1,
    input  wire logic                    loopRequestB2,
    input  wire logic                    comparatorB1,
    input  wire logic                    comparatorB2,
    input  wire logic                    auxComparatorB1,
    input  wire logic                    auxComparatorB2,
    // error monitor
    input  wire logic                    errorDetect,
    input  wire logic [7:0]              errorNumber,
    // output stages
    output logic                         stageEnable,
    output logic      [15:0]             branch1Drive,
    output logic      [15:0]             branch1SecondDrive,
    output logic                         errorCompOut,
    // loop control
    output logic                         cmpInputHoldB1,
    output logic                         cmpInputHoldB2,
    output logic                         closedLoopActiveB1,
    output logic                         closedLoopActiveB2,
    // interrupt
    output logic                         irq
);
    import fbec_pkg::*;

    function automatic logic isLoopSelect(input logic [FSEL_W-1:0] fsel);
        isLoopSelect = (fsel == LOOP_SEL_A) || (fsel == LOOP_SEL_B);
    endfunction : isLoopSelect

    // pin synchronisers
    logic [PIN_N-1:0] pinMeta;
    logic [PIN_N-1:0] pinSync;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else if (ce) begin
            pinMeta <= {auxComparatorB2, auxComparatorB1, comparatorB2,
                        comparatorB1, loopRequestB2, loopRequestB1,
                        pinEnable};
            pinSync <= pinMeta;
        end
    end

    logic                pinEnableActive;
    logic [BRANCHES-1:0] loopReq;
    logic [BRANCHES-1:0] compState;
    logic [BRANCHES-1:0] auxState;

    assign pinEnableActive = pinSync[0];
    assign loopReq         = pinSync[2:1];
    assign compState       = pinSync[4:3];
    assign auxState        = pinSync[6:5];

    // telegram assembly
    fbec_frame_if frame ();
    logic telegramWrite;
    assign telegramWrite = regWrite && (regAddr == REG_TELEGRAM);
    fbec_telegram_rx u_rx (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .ce         (ce),
        .byteValid  (telegramWrite),
        .byteData   (regWrData[7:0]),
        .frameStart (regWrData[TG_START_BIT]),
        .frame      (frame)
    );

    // core state
    logic [7:0]          specialFunctionByte;
    logic [7:0]          next_specialFunctionByte;
    logic [15:0]         setValue1;
    logic [15:0]         next_setValue1;
    logic [15:0]         setValue2;
    logic [15:0]         next_setValue2;
    logic [15:0]         cfgWord;
    logic [15:0]         next_config;
    logic                busDisPrev;
    logic                pinPrev;
    logic                errorLatched;
    logic                next_errorLatched;
    logic                next_stageEnable;
    logic [15:0]         next_branch1Drive;
    logic [15:0]         next_branch1SecondDrive;
    logic                next_errorCompOut;
    logic [BRANCHES-1:0] cmpHold;
    logic [BRANCHES-1:0] next_cmpHold;
    logic [IRQ_N-1:0]    irqStatus;
    logic [IRQ_N-1:0]    next_irqStatus;
    logic [IRQ_N-1:0]    irqMask;
    logic [IRQ_N-1:0]    next_irqMask;
    logic [DATA_W-1:0]   next_regRdData;
    logic                busDisable;
    logic                comparatorOutputTest;
    logic                errorActive;
    logic                errorAck;
    logic                frameAccept;
    logic [7:0]          testPermit;
    logic [FSEL_W-1:0]   fsel [BRANCHES];
    fbec_loop_t          loopState [BRANCHES];
    logic [BRANCHES-1:0] loopEnter;
    logic [BRANCHES-1:0] closedFlags;
    logic [7:0]          statusHigh;

    assign busDisable           = specialFunctionByte[CTRL_BUSDIS_BIT];
    assign comparatorOutputTest = specialFunctionByte[CTRL_TEST_BIT];
    assign errorActive          = errorLatched || errorDetect;
    assign testPermit           = cfgWord[CFG_PERMIT_LSB +: 8];
    assign fsel[0]              = cfgWord[CFG_FSEL1_LSB +: FSEL_W];
    assign fsel[1]              = cfgWord[CFG_FSEL2_LSB +: FSEL_W];
    // acknowledge by bus disable release or enable pin drop
    assign errorAck    = (busDisPrev && !busDisable)
                       || (pinPrev && !pinEnableActive);
    assign frameAccept = frame.frameDone
                       && (frame.command == CMD_PROCESS);

    always_comb begin
        statusHigh                  = 8'h00;
        statusHigh[STAT_HWEN_BIT]   = pinEnableActive;
        statusHigh[STAT_ERR_BIT]    = errorActive;
        statusHigh[STAT_BUSDIS_BIT] = busDisable;
    end

    always_comb begin
        next_specialFunctionByte = specialFunctionByte;
        if (!pinEnableActive) begin
            next_specialFunctionByte = CTRL_RESET;
        end else if (frameAccept) begin
            next_specialFunctionByte = frame.specialFunctionByte
                                     & CTRL_KEEP_MASK;
        end

        next_setValue1 = setValue1;
        next_setValue2 = setValue2;
        if (errorActive) begin
            next_setValue1 = SETVAL_RESET;
            next_setValue2 = SETVAL_RESET;
        end else if (frameAccept) begin
            next_setValue1 = frame.branch1SetValue;
            next_setValue2 = frame.branch1SecondSetValue;
        end
        // a new error wins over an acknowledge in the same cycle
        next_errorLatched = errorLatched;
        if (errorDetect) begin
            next_errorLatched = 1'b1;
        end else if (errorAck) begin
            next_errorLatched = 1'b0;
        end

        next_stageEnable = pinEnableActive && !busDisable
                         && !errorActive;
        next_branch1Drive       = next_stageEnable ? setValue1 : SETVAL_RESET;
        next_branch1SecondDrive = next_stageEnable ? setValue2 : SETVAL_RESET;
        next_errorCompOut = (comparatorOutputTest && (testPermit != 8'h00)
                             && !errorActive)
                          || (|compState);
        next_cmpHold = ~loopReq;
        next_config  = cfgWord;
        next_irqMask = irqMask;
        next_irqStatus = irqStatus;
        if (regWrite) begin
            if (regAddr == REG_CONFIG) begin
                next_config = regWrData[15:0];
            end else if (regAddr == REG_IRQ_STAT) begin
                next_irqStatus = irqStatus & ~regWrData[IRQ_N-1:0];
            end else if (regAddr == REG_IRQ_MASK) begin
                next_irqMask = regWrData[IRQ_N-1:0];
            end
        end
        next_irqStatus[IRQ_FRAME] = next_irqStatus[IRQ_FRAME] || frameAccept;
        next_irqStatus[IRQ_ERROR] = next_irqStatus[IRQ_ERROR]
                                  || (next_errorLatched && !errorLatched);
        next_irqStatus[IRQ_PIN]   = next_irqStatus[IRQ_PIN]
                                  || (pinPrev != pinEnableActive);
        next_irqStatus[IRQ_LOOP1] = next_irqStatus[IRQ_LOOP1] || loopEnter[0];
        next_irqStatus[IRQ_LOOP2] = next_irqStatus[IRQ_LOOP2] || loopEnter[1];

        next_regRdData = '0;
        if (regRead) begin
            if (regAddr == REG_CONFIG) begin
                next_regRdData[15:0] = cfgWord;
            end else if (regAddr == REG_STATUS) begin
                next_regRdData[15:8] = statusHigh;
                next_regRdData[7:0]  = errorActive ? errorNumber : 8'h00;
            end else if (regAddr == REG_LOOP) begin
                next_regRdData[LS_CLOSED_LSB +: BRANCHES] = closedFlags;
                next_regRdData[LS_COMP_LSB +: BRANCHES]   = compState;
                next_regRdData[LS_AUX_LSB +: BRANCHES]    = auxState;
                next_regRdData[LS_CTRL_LSB +: 8] = specialFunctionByte;
            end else if (regAddr == REG_SETVAL) begin
                next_regRdData = {setValue2, setValue1};
            end else if (regAddr == REG_IRQ_STAT) begin
                next_regRdData[IRQ_N-1:0] = irqStatus;
            end else if (regAddr == REG_IRQ_MASK) begin
                next_regRdData[IRQ_N-1:0] = irqMask;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            specialFunctionByte <= CTRL_RESET;
            setValue1           <= SETVAL_RESET;
            setValue2           <= SETVAL_RESET;
            cfgWord             <= CFG_RESET;
            busDisPrev          <= 1'b0;
            pinPrev             <= 1'b0;
            errorLatched        <= 1'b0;
            stageEnable         <= 1'b0;
            branch1Drive        <= SETVAL_RESET;
            branch1SecondDrive  <= SETVAL_RESET;
            errorCompOut        <= 1'b0;
            cmpHold             <= '1;
            irqStatus           <= IRQ_RESET;
            irqMask             <= IRQ_RESET;
            regRdData           <= '0;
        end else if (ce) begin
            specialFunctionByte <= next_specialFunctionByte;
            setValue1           <= next_setValue1;
            setValue2           <= next_setValue2;
            cfgWord             <= next_config;
            busDisPrev          <= busDisable;
            pinPrev             <= pinEnableActive;
            errorLatched        <= next_errorLatched;
            stageEnable         <= next_stageEnable;
            branch1Drive        <= next_branch1Drive;
            branch1SecondDrive  <= next_branch1SecondDrive;
            errorCompOut        <= next_errorCompOut;
            cmpHold             <= next_cmpHold;
            irqStatus           <= next_irqStatus;
            irqMask             <= next_irqMask;
            regRdData           <= next_regRdData;
        end
    end

    // remote loop switchover per branch
    for (genvar b = 0; b < BRANCHES; b++) begin : g_branch
        fbec_loop_t next_state;

        always_comb begin
            next_state = loopState[b];
            case (loopState[b])
                LOOP_OPEN: begin
                    if (isLoopSelect(fsel[b]) && loopReq[b]
                        && !compState[b]) begin
                        next_state = LOOP_CLOSED;
                    end
                end
                LOOP_CLOSED: begin
                    if (!loopReq[b]) begin
                        next_state = LOOP_OPEN;
                    end
                end
                default: next_state = LOOP_OPEN;
            endcase
        end

        always_ff @(posedge core_clk or negedge rst_n) begin
            if (!rst_n) begin
                loopState[b] <= LOOP_OPEN;
            end else if (ce) begin
                loopState[b] <= next_state;
            end
        end

        assign loopEnter[b]   = ce && (loopState[b] == LOOP_OPEN)
                              && (next_state == LOOP_CLOSED);
        assign closedFlags[b] = (loopState[b] == LOOP_CLOSED);
    end

    assign closedLoopActiveB1 = closedFlags[0];
    assign closedLoopActiveB2 = closedFlags[1];
    assign cmpInputHoldB1     = cmpHold[0];
    assign cmpInputHoldB2     = cmpHold[1];
    assign irq                = |(irqStatus & irqMask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    chk_enable_needs_pin: assert property (
        stageEnable |-> $past(pinEnableActive))
        else $error("stage enabled without enable pin");
    chk_busdis_blocks: assert property (
        $past(busDisable) |-> !stageEnable && (branch1Drive == 16'h0000))
        else $error("outputs active under bus disable");
    chk_error_ack: assert property (
        ce && $fell(busDisable) && !errorDetect |=> !errorLatched)
        else $error("bus disable release did not clear error");
    chk_pin_low_clears: assert property (
        ce && !pinEnableActive |=> !busDisable && (specialFunctionByte == 8'h00))
        else $error("control byte kept while enable pin low");
    chk_status_bits: assert property (
        ce && regRead && (regAddr == REG_STATUS) |=>
        regRdData[15] == $past(busDisable)
        && regRdData[10] == $past(pinEnableActive)
        && regRdData[11] == $past(errorActive))
        else $error("status high byte wrong");
    chk_hold_zero: assert property (
        ce && !loopReq[0] |=> cmpInputHoldB1)
        else $error("branch 1 comparator inputs released early");
    chk_close_cond: assert property (
        $rose(closedLoopActiveB1) |-> $past(isLoopSelect(fsel[0])
        && loopReq[0] && !compState[0]))
        else $error("branch 1 closed loop without conditions");
    chk_close_stays: assert property (
        ce && closedLoopActiveB2 && loopReq[1] |=> closedLoopActiveB2)
        else $error("branch 2 left closed loop while requested");
    chk_aux_status: assert property (
        ce && regRead && (regAddr == REG_LOOP) |=>
        regRdData[5:4] == $past(auxState))
        else $error("aux comparator status wrong");
    chk_test_force: assert property (
        $past(comparatorOutputTest && (testPermit != 8'h00) && !errorActive)
        |-> errorCompOut)
        else $error("comparator test did not force output");
    chk_ignored_bits: assert property (
        (specialFunctionByte & CTRL_IGNORED) == 8'h00)
        else $error("ignored control bits stored");
    chk_error_discards: assert property (
        $past(errorActive) |-> !stageEnable && (setValue1 == 16'h0000))
        else $error("set points kept during error");
    chk_cmd_only: assert property (
        ce && frame.frameDone && (frame.command != CMD_PROCESS)
        && !errorActive |=> $stable(setValue1) && $stable(setValue2))
        else $error("foreign command changed set values");

    cov_loop_closed: cover property ($rose(closedLoopActiveB1));
    cov_error_ack:   cover property ($fell(errorLatched));
    cov_test_force:  cover property (comparatorOutputTest && errorCompOut);
    cov_frame:       cover property (frameAccept && stageEnable);

endmodule : fbec_top

// ### shared/fbec_frame_if.sv
/*
 * Carries one assembled process-data telegram from the byte assembler
 * to the control core. Assumes both ends run on the core clock.
 */
interface fbec_frame_if;
    logic        frameDone;
    logic [7:0]  telegramTag;
    logic [7:0]  slaveCount;
    logic [7:0]  command;
    logic [7:0]  specialFunctionByte;
    logic [15:0] branch1SetValue;
    logic [15:0] branch1SecondSetValue;

    modport assembler (
        output frameDone, telegramTag, slaveCount, command,
               specialFunctionByte, branch1SetValue, branch1SecondSetValue
    );
    modport consumer (
        input  frameDone, telegramTag, slaveCount, command,
               specialFunctionByte, branch1SetValue, branch1SecondSetValue
    );
endinterface : fbec_frame_if

// ### shared/fbec_pkg.sv
/*
 * Shared constants and types of the fieldbus enable and control byte block:
 * register indices, field positions, reset values and the loop state type.
 * Assumes a single core clock domain; registers sit at word indices.
 */
package fbec_pkg;

    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 32;
    localparam int          FSEL_W          = 3;
    localparam int          TELEGRAM_LEN    = 8;
    localparam int          BRANCHES        = 2;
    localparam int          PIN_N           = 7;
    localparam int          IRQ_N           = 5;

    // register indices
    localparam logic [3:0]  REG_TELEGRAM    = 4'h0;
    localparam logic [3:0]  REG_CONFIG      = 4'h1;
    localparam logic [3:0]  REG_STATUS      = 4'h2;
    localparam logic [3:0]  REG_LOOP        = 4'h3;
    localparam logic [3:0]  REG_SETVAL      = 4'h4;
    localparam logic [3:0]  REG_IRQ_STAT    = 4'h5;
    localparam logic [3:0]  REG_IRQ_MASK    = 4'h6;

    // telegram
    localparam logic [7:0]  CMD_PROCESS     = 8'h0F;
    localparam int          TG_START_BIT    = 8;

    // control byte
    localparam int          CTRL_TEST_BIT   = 2;
    localparam int          CTRL_BUSDIS_BIT = 7;
    localparam logic [7:0]  CTRL_KEEP_MASK  = 8'hEE;
    localparam logic [7:0]  CTRL_IGNORED    = 8'h11;
    localparam logic [7:0]  CTRL_RESET      = 8'h00;

    // status high byte
    localparam int          STAT_HWEN_BIT   = 2;
    localparam int          STAT_ERR_BIT    = 3;
    localparam int          STAT_BUSDIS_BIT = 7;

    // function selects that allow remote loop
    localparam logic [2:0]  LOOP_SEL_A      = 3'h2;
    localparam logic [2:0]  LOOP_SEL_B      = 3'h4;

    // config register fields
    localparam int          CFG_FSEL1_LSB   = 0;
    localparam int          CFG_FSEL2_LSB   = 4;
    localparam int          CFG_PERMIT_LSB  = 8;
    localparam logic [15:0] CFG_RESET       = 16'h0000;

    // loop status register fields
    localparam int          LS_CLOSED_LSB   = 0;
    localparam int          LS_COMP_LSB     = 2;
    localparam int          LS_AUX_LSB      = 4;
    localparam int          LS_CTRL_LSB     = 8;

    // interrupt bits
    localparam int          IRQ_FRAME       = 0;
    localparam int          IRQ_ERROR       = 1;
    localparam int          IRQ_PIN         = 2;
    localparam int          IRQ_LOOP1       = 3;
    localparam int          IRQ_LOOP2       = 4;
    localparam logic [4:0]  IRQ_RESET       = 5'h00;

    localparam logic [15:0] SETVAL_RESET    = 16'h0000;

    typedef enum logic [0:0] {
        LOOP_OPEN   = 1'b0,
        LOOP_CLOSED = 1'b1
    } fbec_loop_t;

endpackage : fbec_pkg

// ### test/fbec_master_model.sv
/* fieldbus master model: telegrams and register reads on the port.
   assumes one core clock; strobes change just after a rising edge. */
module fbec_master_model (
    // clock
    input  wire logic        core_clk,
    // register port
    output logic [3:0]       regAddr,
    output logic [31:0]      regWrData,
    output logic             regWrite,
    output logic             regRead,
    input  wire logic [31:0] regRdData
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {regAddr, regWrData, regWrite, regRead} = '0;
    end
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {regAddr, regWrData, regWrite} <= {a, d, 1'b1};
        @(posedge core_clk);
        regWrite <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge core_clk);
        {regAddr, regRead} <= {a, 1'b1};
        @(posedge core_clk);
        regRead <= 1'b0;
        @(negedge core_clk);
        d = regRdData;
    endtask : rd
    // tag, count 1, command, control, set values high byte first
    task automatic send(input logic [7:0] cmd, c, input logic [15:0] s);
        logic [7:0] b [8];
        b = '{8'h23, 8'h01, cmd, c, s[15:8], s[7:0], ~s[15:8], ~s[7:0]};
        for (int i = 0; i < 8; i++) wr(4'h0, {23'h0, i == 0, b[i]});
    endtask : send
endmodule : fbec_master_model

// ### test/tb_fieldbus_enable_and_control_byte.sv
/* bench: frame table, then error, pin, loop and interrupt cases.
   assumes the master model owns the register port. */
module tb_fieldbus_enable_and_control_byte;
    import fbec_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {
        logic [7:0] cmd, c, st;
        logic [15:0] s, drv;
        logic [7:0] ctl;
        logic eo;
    } fbec_row_t;
    logic core_clk = 0, rst_n = 0, pinEnable = 0, errorDetect = 0, ce = 1;
    logic loopRequestB1 = 0, loopRequestB2 = 0, comparatorB1 = 0;
    logic comparatorB2 = 0, auxComparatorB1 = 0, auxComparatorB2 = 0;
    logic [7:0] errorNumber = 8'h00;
    logic [3:0] regAddr;
    logic [31:0] regWrData, regRdData, d;
    logic regWrite, regRead, stageEnable, errorCompOut, irq;
    logic [15:0] branch1Drive, branch1SecondDrive;
    logic cmpInputHoldB1, cmpInputHoldB2, closedLoopActiveB1;
    logic closedLoopActiveB2;
    int fail_count = 0, check_count = 0;
    fbec_row_t rows [5] = '{
        '{8'h0F, 8'h00, 8'h04, 16'h03E8, 16'h03E8, 8'h00, 1'b0},
        '{8'h0F, 8'h80, 8'h84, 16'h1234, 16'h0000, 8'h80, 1'b0},
        '{8'h0F, 8'h11, 8'h04, 16'h0555, 16'h0555, 8'h00, 1'b0},
        '{8'h0E, 8'h80, 8'h04, 16'h7777, 16'h0555, 8'h00, 1'b0},
        '{8'h0F, 8'h04, 8'h04, 16'h0100, 16'h0100, 8'h04, 1'b1}};
    fbec_master_model m (.core_clk, .regAddr, .regWrData, .regWrite,
        .regRead, .regRdData);
    fbec_top DUT (.core_clk, .rst_n, .ce, .regAddr, .regWrData,
        .regWrite, .regRead, .regRdData, .pinEnable, .loopRequestB1,
        .loopRequestB2, .comparatorB1, .comparatorB2, .auxComparatorB1,
        .auxComparatorB2, .errorDetect, .errorNumber, .stageEnable,
        .branch1Drive, .branch1SecondDrive, .errorCompOut, .cmpInputHoldB1,
        .cmpInputHoldB2, .closedLoopActiveB1, .closedLoopActiveB2, .irq);
    initial begin
        forever #20 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, exp);
        check_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: %h vs %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        @(negedge core_clk);
    endtask : tick
    task automatic test_done;
        if (fail_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : test_done
    initial begin
        #(40 * 20000);
        fail_count++;
        test_done();
    end
    initial begin
        tick(20);
        check(cmpInputHoldB1, 1'b1);
        @(posedge core_clk) rst_n <= 1'b1;
        m.send(CMD_PROCESS, 8'h80, 16'h03E8);
        tick(4);
        m.rd(REG_LOOP, d);
        check(d[15:8], 8'h00);
        check(stageEnable, 1'b0);
        m.wr(REG_CONFIG, 32'h0142);
        @(posedge core_clk) pinEnable <= 1'b1;
        foreach (rows[i]) begin
            m.send(rows[i].cmd, rows[i].c, rows[i].s);
            tick(4);
            m.rd(REG_STATUS, d);
            check(d[15:8], rows[i].st);
            check(branch1Drive, rows[i].drv);
            check(stageEnable, rows[i].drv != 0);
            d = rows[i].drv ? rows[i].drv ^ 16'hFFFF : 16'h0000;
            check(branch1SecondDrive, d);
            m.rd(REG_LOOP, d);
            check(d[15:8], rows[i].ctl);
            check(errorCompOut, rows[i].eo);
        end
        @(posedge core_clk) {errorDetect, errorNumber} <= {1'b1, 8'h03};
        tick(4);
        m.rd(REG_STATUS, d);
        check(d[15:0], 16'h0C03);
        check({stageEnable, branch1Drive, branch1SecondDrive}, 33'h0);
        check(errorCompOut, 1'b0);
        @(posedge core_clk) errorDetect <= 1'b0;
        m.send(CMD_PROCESS, 8'h80, 16'h0200);
        m.send(CMD_PROCESS, 8'h00, 16'h0200);
        tick(4);
        m.rd(REG_STATUS, d);
        check(d[15:0], 16'h0400);
        m.send(CMD_PROCESS, 8'h80, 16'h0200);
        @(posedge core_clk) pinEnable <= 1'b0;
        tick(4);
        check(stageEnable, 1'b0);
        @(posedge core_clk) pinEnable <= 1'b1;
        tick(4);
        m.rd(REG_STATUS, d);
        check(d[15:8], 8'h04);
        check({cmpInputHoldB1, cmpInputHoldB2}, 2'b11);
        @(posedge core_clk) {loopRequestB1, loopRequestB2} <= 2'b11;
        tick(4);
        check({closedLoopActiveB1, cmpInputHoldB1}, 2'b10);
        check({closedLoopActiveB2, cmpInputHoldB2}, 2'b10);
        @(posedge core_clk) {comparatorB1, auxComparatorB1} <= 2'b11;
        tick(4);
        check(closedLoopActiveB1, 1'b1);
        m.rd(REG_LOOP, d);
        check(d[5:4], 2'b01);
        @(posedge core_clk) {loopRequestB1, loopRequestB2} <= 2'b00;
        m.wr(REG_CONFIG, 32'h0143);
        @(posedge core_clk) {loopRequestB1, loopRequestB2, comparatorB1,
            comparatorB2} <= 4'b0001;
        @(posedge core_clk) {loopRequestB1, loopRequestB2} <= 2'b11;
        tick(4);
        check({closedLoopActiveB1, closedLoopActiveB2}, 2'b00);
        m.wr(REG_IRQ_MASK, 32'h1);
        m.wr(REG_IRQ_STAT, 32'h1F);
        tick(1);
        check(irq, 1'b0);
        @(posedge core_clk) ce <= 1'b0;
        m.wr(REG_IRQ_MASK, 32'h0);
        @(posedge core_clk) ce <= 1'b1;
        m.send(CMD_PROCESS, 8'h00, 16'h0300);
        tick(4);
        check(irq, 1'b1);
        test_done();
    end
endmodule : tb_fieldbus_enable_and_control_byte
